// ==== design/ves_cmd_decode.sv ====
// Turns a write of the command field into at most one command pulse; reserved codes give none.
// Assumes the write strobe is one cycle long and synchronous to clock.
`timescale 1ns/1ps
module ves_cmd_decode
  import ves_pkg::*;
(
  // Register write side
  input wire logic wr_en,
  input wire logic [CMD_W-1:0] wr_cmd,
  // Decoded pulses
  ves_cmd_if.src cmd
);
  always_comb
  begin
    cmd.start = 1'b0;
    cmd.pause = 1'b0;
    cmd.step = 1'b0;
    cmd.resume = 1'b0;
    cmd.stop = 1'b0;
    if (wr_en)
    begin
      unique case (wr_cmd)
        CMD_START: cmd.start = 1'b1;
        CMD_PAUSE: cmd.pause = 1'b1;
        CMD_STEP: cmd.step = 1'b1;
        CMD_RESUME: cmd.resume = 1'b1;
        CMD_STOP: cmd.stop = 1'b1;
        default: cmd.start = 1'b0;
      endcase
    end
  end
endmodule : ves_cmd_decode

// ==== design/ves_cmd_if.sv ====
// Interface carrying decoded one-cycle command pulses from the decoder to the control core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ves_cmd_if;
  logic start;
  logic pause;
  logic step;
  logic resume;
  logic stop;
  modport src (output start, output pause, output step, output resume, output stop);
  modport dst (input start, input pause, input step, input resume, input stop);
endinterface : ves_cmd_if

// ==== design/ves_exec_status_regs.sv ====
// Command, memory-format and status registers with the run/pause sequencer of the decoder.
// Assumes the datapath reports window, symbol, error and channel events as one-cycle pulses.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ves_exec_status_regs
  import ves_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // System byte order
  input wire logic big_endian,
  // Datapath events
  input wire logic window_sm_done,
  input wire logic symbol_done,
  input wire logic decode_done,
  input wire logic error_event,
  input wire logic fault_cause_read,
  input wire logic config_loaded,
  input wire logic [CNT_W-1:0] symbol_limit,
  // Queue and debug levels
  input wire logic in_queue_empty,
  input wire logic in_queue_low,
  input wire logic out_queue_full,
  input wire logic debug_halt_flag,
  // Control outputs
  output logic start_pulse,
  output logic traceback_go,
  output logic soft_reset,
  output logic sm_hold,
  output logic running,
  output logic paused,
  output logic branch_metric_format,
  output logic softdec_format
);
  ves_cmd_if cmd_bus ();

  logic [CMD_W-1:0] execution_command;
  logic [FMT_W-1:0] memory_format_select;
  logic [CNT_W-1:0] processed_symbol_count;
  logic awaiting_config;
  logic err_flag;
  logic fifo_pause;
  logic in_empty_q;
  logic out_full_q;
  logic halt_q;
  logic exec_wr;
  logic fmt_wr;
  logic fifo_stall;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] next_rdata;
  ves_state_t state;
  ves_state_t next_state;

  assign exec_wr = reg_wr && (reg_addr == ADDR_EXEC);
  assign fmt_wr = reg_wr && (reg_addr == ADDR_FMT);
  assign fifo_stall = in_queue_low || out_queue_full;

  ves_cmd_decode u_decode
  (
    .wr_en(exec_wr),
    .wr_cmd(reg_wdata[CMD_W-1:0]),
    .cmd(cmd_bus)
  );

  // Command register is not cleared by a stop command; it takes the written stop code.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      execution_command <= EXEC_RESET;
    end
    else if (exec_wr)
    begin
      execution_command <= reg_wdata[CMD_W-1:0];
    end
  end

  // Format register also survives a stop command.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      memory_format_select <= FMT_RESET;
    end
    else if (fmt_wr)
    begin
      memory_format_select <= reg_wdata[FMT_W-1:0];
    end
  end

  // Formats fall back to packed words in little-endian operation.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      branch_metric_format <= 1'b0;
      softdec_format <= 1'b0;
    end
    else
    begin
      branch_metric_format <= big_endian && memory_format_select[FMT_BM_BIT];
      softdec_format <= big_endian && memory_format_select[FMT_SD_BIT];
    end
  end

  // Sequencer next state.
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE:
      begin
        if (cmd_bus.start)
        begin
          next_state = S_RUN;
        end
      end
      S_RUN:
      begin
        if (decode_done)
        begin
          next_state = S_IDLE;
        end
        else if (error_event || fifo_stall)
        begin
          next_state = S_PAUSED;
        end
        else if (cmd_bus.pause)
        begin
          next_state = S_DRAIN;
        end
      end
      S_DRAIN:
      begin
        if (decode_done)
        begin
          next_state = S_IDLE;
        end
        else if (window_sm_done || error_event)
        begin
          next_state = S_PAUSED;
        end
      end
      S_STEP:
      begin
        if (decode_done)
        begin
          next_state = S_IDLE;
        end
        else if (window_sm_done || error_event)
        begin
          next_state = S_PAUSED;
        end
      end
      S_PAUSED:
      begin
        if (cmd_bus.step)
        begin
          next_state = S_STEP;
        end
        else if (cmd_bus.resume)
        begin
          next_state = S_RUN;
        end
        else if (fifo_pause && !fifo_stall && !err_flag)
        begin
          next_state = S_RUN;
        end
      end
    endcase
    if (cmd_bus.stop)
    begin
      next_state = S_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Remembers that the current pause came from a queue, so it lifts by itself.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fifo_pause <= 1'b0;
    end
    else if (cmd_bus.stop || cmd_bus.step || cmd_bus.resume || next_state != S_PAUSED)
    begin
      fifo_pause <= 1'b0;
    end
    else if (state == S_RUN && fifo_stall && !error_event && !decode_done)
    begin
      fifo_pause <= 1'b1;
    end
  end

  // Command pulses towards the datapath.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      start_pulse <= 1'b0;
      traceback_go <= 1'b0;
      soft_reset <= 1'b0;
    end
    else
    begin
      start_pulse <= (state == S_IDLE) && cmd_bus.start && !cmd_bus.stop;
      traceback_go <= (state == S_PAUSED) && (cmd_bus.step || cmd_bus.resume);
      soft_reset <= cmd_bus.stop;
    end
  end

  // Run and pause levels.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      running <= 1'b0;
      paused <= 1'b0;
      sm_hold <= 1'b0;
    end
    else
    begin
      running <= (next_state == S_RUN) || (next_state == S_DRAIN) || (next_state == S_STEP);
      paused <= (next_state == S_PAUSED);
      sm_hold <= (next_state == S_PAUSED) || (next_state == S_IDLE);
    end
  end

  // Processed symbol count, cleared by a stop or by a start from idle, and held at the frame limit.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      processed_symbol_count <= CNT_RESET;
    end
    else if (cmd_bus.stop || (state == S_IDLE && cmd_bus.start))
    begin
      processed_symbol_count <= CNT_RESET;
    end
    else if (symbol_done && processed_symbol_count < symbol_limit)
    begin
      processed_symbol_count <= processed_symbol_count + CNT_ONE;
    end
  end

  // Waiting-for-configuration flag; a finished channel wins over a configuration load.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awaiting_config <= 1'b0;
    end
    else if (cmd_bus.stop)
    begin
      awaiting_config <= 1'b0;
    end
    else if (decode_done)
    begin
      awaiting_config <= 1'b1;
    end
    else if (config_loaded)
    begin
      awaiting_config <= 1'b0;
    end
  end

  // Error flag; a new error in the same cycle as the error-register read stays set.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      err_flag <= 1'b0;
    end
    else if (cmd_bus.stop)
    begin
      err_flag <= 1'b0;
    end
    else if (error_event && state != S_IDLE)
    begin
      err_flag <= 1'b1;
    end
    else if (fault_cause_read)
    begin
      err_flag <= 1'b0;
    end
  end

  // Queue and emulation levels sampled into status.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      in_empty_q <= IEMPTY_RESET;
      out_full_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      in_empty_q <= in_queue_empty;
      out_full_q <= out_queue_full;
      halt_q <= debug_halt_flag;
    end
  end

  // Status word; reserved bits are constant zero.
  always_comb
  begin
    status_word = '0;
    status_word[ST_CNT_HI:ST_CNT_LO] = processed_symbol_count;
    status_word[ST_EHALT] = halt_q;
    status_word[ST_OFULL] = out_full_q;
    status_word[ST_IEMPTY] = in_empty_q;
    status_word[ST_WAIT] = awaiting_config;
    status_word[ST_ERR] = err_flag;
    status_word[ST_RUN] = running;
    status_word[ST_PAUSE] = paused;
  end

  // Read mux; unmapped addresses read zero.
  always_comb
  begin
    next_rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_EXEC: next_rdata[CMD_W-1:0] = execution_command;
        ADDR_FMT: next_rdata[FMT_W-1:0] = memory_format_select;
        ADDR_STAT: next_rdata = status_word;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end
endmodule : ves_exec_status_regs

// ==== design/ves_pkg.sv ====
// Constants, register map and state encoding for the decoder command and status registers.
// Assumes a 32-bit register port with read data returned one cycle after the read strobe.
// Function
// - Decode four-bit command field; zero is no instruction, six and above reserved.
// - Command one starts decoding in normal mode.
// - Command two pauses after the current window's state metrics, before traceback.
// - Command three resumes traceback, runs one more window, then pauses again.
// - Command four resumes traceback and runs to normal completion.
// - Command five stops and soft-resets all but command, format and internal registers.
// - Reserved bits of command, format and status registers read zero, ignore writes.
// - Format selections apply only in big-endian operation, ignored in little-endian.
// - Format bit one selects soft-decision output: packed words or native bytes.
// - Format bit zero selects branch metric input: packed words or native bytes.
// - Status bits 28 to 12 count symbols processed; read-only, reset to zero.
// - Count stops at frame plus constraint minus one, or frame plus convergence.
// - Status bit six shows halt by emulation; resets to zero.
// - Status bit five shows output decision queue full; resets to zero.
// - Status bit four shows input branch metric queue empty; resets to one.
// - Status bit three shows awaiting configuration; always set after a channel finishes. A stop command in the same cycle leaves it clear.
// - Status bit two set on error pause; cleared when the error register is read.
// - Status bit one shows a decode is running.
// - Pause command acknowledged by setting bit zero, resume by clearing it.
// - Device pauses itself when input queue runs low or output queue is full.
package ves_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 17;
  localparam int CMD_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_EXEC = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FMT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
  localparam logic [CMD_W-1:0] CMD_NONE = 4'h0;
  localparam logic [CMD_W-1:0] CMD_START = 4'h1;
  localparam logic [CMD_W-1:0] CMD_PAUSE = 4'h2;
  localparam logic [CMD_W-1:0] CMD_STEP = 4'h3;
  localparam logic [CMD_W-1:0] CMD_RESUME = 4'h4;
  localparam logic [CMD_W-1:0] CMD_STOP = 4'h5;
  localparam int FMT_BM_BIT = 0;
  localparam int FMT_SD_BIT = 1;
  localparam int FMT_W = 2;
  localparam int ST_PAUSE = 0;
  localparam int ST_RUN = 1;
  localparam int ST_ERR = 2;
  localparam int ST_WAIT = 3;
  localparam int ST_IEMPTY = 4;
  localparam int ST_OFULL = 5;
  localparam int ST_EHALT = 6;
  localparam int ST_CNT_LO = 12;
  localparam int ST_CNT_HI = 28;
  localparam logic [CMD_W-1:0] EXEC_RESET = 4'h0;
  localparam logic [FMT_W-1:0] FMT_RESET = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 17'h00000;
  localparam logic [CNT_W-1:0] CNT_ONE = 17'h00001;
  localparam logic IEMPTY_RESET = 1'b1;
  typedef enum logic [4:0]
  {
    S_IDLE = 5'b00001,
    S_RUN = 5'b00010,
    S_DRAIN = 5'b00100,
    S_PAUSED = 5'b01000,
    S_STEP = 5'b10000
  } ves_state_t;
endpackage : ves_pkg

// ==== test/ves_exec_status_regs_chk.sv ====
// Concurrent checks on the decoder command and status register ports.
// Assumes it is bound to every instance of the top module.
`timescale 1ns/1ps
module ves_exec_status_regs_chk
  import ves_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Levels
  input wire logic big_endian,
  input wire logic in_queue_empty,
  input wire logic in_queue_low,
  input wire logic out_queue_full,
  input wire logic debug_halt_flag,
  // Outputs
  input wire logic start_pulse,
  input wire logic traceback_go,
  input wire logic soft_reset,
  input wire logic running,
  input wire logic paused,
  input wire logic branch_metric_format,
  input wire logic softdec_format
);
  logic [1:0] up;
  wire wexe = reg_wr && reg_addr == ADDR_EXEC;
  wire go_ok = wexe && paused && !in_queue_low && !out_queue_full;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Keeps level checks away from values sampled during reset.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  a_stat_resv: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_STAT
    |-> reg_rdata[31:29] == 3'h0 && reg_rdata[11:7] == 5'h00) else $error("status reserved bits set");
  a_exec_resv: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_EXEC
    |-> reg_rdata[31:4] == 28'h0) else $error("command reserved bits set");
  a_start_run: assert property (wexe && reg_wdata[3:0] == CMD_START && !running && !paused
    |=> start_pulse && running) else $error("start did not run");
  a_step_go: assert property (go_ok && reg_wdata[3:0] == CMD_STEP
    |=> traceback_go && running && !paused) else $error("step did not resume");
  a_resume_go: assert property (go_ok && reg_wdata[3:0] == CMD_RESUME
    |=> traceback_go && running && !paused) else $error("resume did not resume");
  a_stop_clear: assert property (wexe && reg_wdata[3:0] == CMD_STOP
    |=> soft_reset && !running && !paused) else $error("stop did not clear");
  a_fmt_little: assert property (branch_metric_format || softdec_format
    |-> $past(big_endian)) else $error("format used in little endian");
  a_run_excl: assert property (!(running && paused)) else $error("running while paused");
  a_stat_bits: assert property (up == 2'h3 && $past(reg_rd) && $past(reg_addr) == ADDR_STAT
    |-> reg_rdata[6:4] == {$past(debug_halt_flag, 2), $past(out_queue_full, 2), $past(in_queue_empty, 2)})
    else $error("status level bits wrong");
  a_stat_run: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_STAT
    |-> reg_rdata[1:0] == {$past(running), $past(paused)}) else $error("status run bits wrong");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside read");
endmodule : ves_exec_status_regs_chk
bind ves_exec_status_regs ves_exec_status_regs_chk ves_exec_status_regs_chk_inst (.*);

// ==== test/ves_exec_status_regs_tb.sv ====
// Self-checking bench for the decoder command and status registers.
// Assumes the checker is bound to the design instance.
`timescale 1ns/1ps
module ves_exec_status_regs_tb
  import ves_pkg::*;
;
  logic clock, rst, reg_wr, reg_rd, big_endian, in_queue_empty, in_queue_low, out_queue_full, debug_halt_flag;
  logic start_pulse, traceback_go, soft_reset, sm_hold, running, paused, bm_fmt, sd_fmt;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
  logic [CNT_W-1:0] symbol_limit;
  logic [5:0] ev;
  int miscompares, samples_checked, cycles;
  logic [7:0] ra [6] = '{ADDR_EXEC, ADDR_EXEC, ADDR_FMT, ADDR_FMT, ADDR_STAT, 8'h0c};
  logic [31:0] rw [6] = '{32'hffff_fff7, 32'hffff_fff0, 32'hffff_fffc, 32'hffff_fffe, 32'hffff_ffff, 32'hffff_ffff};
  logic [31:0] rx [6] = '{32'h7, 32'h0, 32'h0, 32'h2, 32'h10, 32'h0};

  ves_exec_status_regs ves_exec_status_regs_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .big_endian(big_endian),
    .window_sm_done(ev[0]), .symbol_done(ev[1]), .decode_done(ev[2]), .error_event(ev[3]),
    .fault_cause_read(ev[4]), .config_loaded(ev[5]), .symbol_limit(symbol_limit),
    .in_queue_empty(in_queue_empty), .in_queue_low(in_queue_low), .out_queue_full(out_queue_full),
    .debug_halt_flag(debug_halt_flag), .start_pulse(start_pulse), .traceback_go(traceback_go),
    .soft_reset(soft_reset), .sm_hold(sm_hold), .running(running), .paused(paused),
    .branch_metric_format(bm_fmt), .softdec_format(sd_fmt));

  task automatic final_report();
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(string n, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  task automatic pulse(int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev <= 6'h00;
    #1;
  endtask : pulse

  task automatic stat(logic [31:0] m, logic [31:0] exp, string n);
    rd(ADDR_STAT);
    chk(n, exp, rd_val & m);
  endtask : stat

  task automatic lvl(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : lvl

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, ev} = 48'h0;
    {big_endian, in_queue_low, out_queue_full, debug_halt_flag, in_queue_empty} = 5'h01;
    symbol_limit = 17'h00004;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    stat(32'hffff_ffff, 32'h10, "status reset");
    rd(ADDR_FMT);
    chk("format reset", FMT_RESET, rd_val);
    for (int i = 0; i < 6; i++)
    begin
      wr(ra[i], rw[i]);
      rd(ra[i]);
      chk("readback", rx[i], rd_val);
    end
    chk("idle run", 0, running);
    chk("little sd", 0, sd_fmt);
    @(posedge clock);
    big_endian <= 1'b1;
    lvl(2);
    chk("big sd", 1, sd_fmt);
    chk("big bm", 0, bm_fmt);
    wr(ADDR_FMT, 32'h1);
    lvl(2);
    chk("bm native", 1, bm_fmt);
    chk("sd packed", 0, sd_fmt);
    wr(ADDR_EXEC, CMD_START);
    chk("start", 1, start_pulse);
    chk("hold run", 0, sm_hold);
    repeat (3) pulse(1);
    stat(32'h1fff_f000, 32'h3000, "count");
    repeat (3) pulse(1);
    stat(32'h1fff_f000, 32'h4000, "count cap");
    wr(ADDR_EXEC, CMD_PAUSE);
    chk("drain run", 1, running);
    pulse(0);
    stat(32'h3, 32'h1, "paused");
    chk("hold paused", 1, sm_hold);
    wr(ADDR_EXEC, CMD_STEP);
    chk("step go", 1, traceback_go);
    pulse(0);
    stat(32'h3, 32'h1, "step paused");
    wr(ADDR_EXEC, CMD_RESUME);
    chk("resume go", 1, traceback_go);
    pulse(0);
    stat(32'h3, 32'h2, "no pause");
    pulse(2);
    stat(32'hb, 32'h8, "done");
    pulse(5);
    stat(32'h8, 32'h0, "configured");
    wr(ADDR_EXEC, CMD_START);
    pulse(3);
    stat(32'h7, 32'h5, "error pause");
    pulse(4);
    stat(32'h4, 32'h0, "error read");
    wr(ADDR_EXEC, CMD_RESUME);
    wr(ADDR_EXEC, 32'h9);
    chk("cmd ignored", 1, running);
    @(posedge clock);
    out_queue_full <= 1'b1;
    lvl(3);
    stat(32'h23, 32'h21, "full pause");
    @(posedge clock);
    {out_queue_full, in_queue_low} <= 2'h1;
    lvl(3);
    stat(32'h23, 32'h01, "low pause");
    @(posedge clock);
    {in_queue_low, in_queue_empty, debug_halt_flag} <= 3'h1;
    lvl(3);
    stat(32'h53, 32'h42, "auto resume");
    wr(ADDR_EXEC, CMD_STOP);
    chk("soft reset", 1, soft_reset);
    stat(32'h1fff_f00f, 32'h0, "after stop");
    rd(ADDR_FMT);
    chk("format kept", 1, rd_val);
    // A reset after the stop command brings the format register and the sequencer back to their initial values.
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_FMT);
    chk("format after reset", FMT_RESET, rd_val);
    chk("reset idle", 0, running);
    chk("reset hold", 1, sm_hold);
    rd(ADDR_EXEC);
    chk("command after reset", EXEC_RESET, rd_val);
    final_report();
  end
endmodule : ves_exec_status_regs_tb
